// ---- inc/tvp_defs.svh ----
// Offsets, field positions, reset values and timing figures of the tuning preset controller.
// Assumes a 25 MHz system clock; every count below is derived from its printed figure.
`ifndef TVP_DEFS_SVH
`define TVP_DEFS_SVH

`define TVP_CLK_NS 40
`define TVP_CLK_HZ 25000000
`define TVP_CYC_DN(ns) ((ns) / `TVP_CLK_NS)

// Register byte offsets
`define TVP_OFS_CTRL 8'h00
`define TVP_OFS_TUNE 8'h04
`define TVP_OFS_STAT 8'h08

// Control register fields
`define TVP_CTRL_SEARCH 0
`define TVP_CTRL_FASTREM 1
`define TVP_CTRL_MODE_LSB 4
`define TVP_CTRL_RST 7'h00

// Tuning register fields
`define TVP_TUNE_BAND_LSB 16
`define TVP_TUNE_FT_LSB 20

// Memory store cycle
`define TVP_MEM_W_US 115
`define TVP_ERASE_T_US 231
`define TVP_WRITE_T_US 462
`define TVP_ERASE_PULSES 500
`define TVP_WRITE_PULSES 950

// Remote fine-tune discrimination
`define TVP_REM_UP_SLOW_US 1800
`define TVP_REM_DN_SLOW_US 1700
`define TVP_REM_UP_FAST_US 120
`define TVP_REM_DN_FAST_US 80
`define TVP_REPEAT_MS 560

// Key acceptance, scan and outputs
`define TVP_ACCEPT_MS 31
`define TVP_SLOW_UP_DHZ 677
`define TVP_SLOW_DN_DHZ 84
`define TVP_FT_HZ 17305
`define TVP_FT_MID 3'h4
`define TVP_BIT_NS 3600
`define TVP_DCLK_W_NS 1300
`define TVP_BURST_REP_US 3690
`define TVP_BURST_BITS 15

`endif

// ---- inc/tvp_pkg.sv ----
// Types shared by the tuning preset controller modules.
// Assumes nothing of its surroundings.
package tvp_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_WRITE} tvp_st_e;

  typedef enum logic [2:0] {
    SC_OFF, SC_FAST_UP, SC_MED_DN, SC_SLOW_UP, SC_SLOW_DN, SC_MAN_UP, SC_MAN_DN
  } tvp_scan_e;

endpackage

// ---- design/tvp_disp_tx.sv ----
// Display burst sender: 15 bits with a clock pulse each, open-drain enables.
// Assumes go is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "tvp_defs.svh"
module tvp_disp_tx
  import tvp_pkg::*;
(
  // Clock, reset and enable
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  // Burst request
  input  wire logic        go,
  input  wire logic [14:0] word,
  // Line enables
  output logic             busy,
  output logic             data_oe,
  output logic             clk_oe
);
  localparam logic [6:0] BITM = 7'(`TVP_CYC_DN(`TVP_BIT_NS) - 1);
  localparam logic [6:0] CLO  = 7'(`TVP_CYC_DN(`TVP_BIT_NS) - `TVP_CYC_DN(`TVP_DCLK_W_NS));
  localparam logic [3:0] LAST = 4'(`TVP_BURST_BITS - 1);

  typedef struct packed {
    logic        act;
    logic [3:0]  bitn;
    logic [6:0]  cyc;
    logic [14:0] sh;
    logic        d_oe;
    logic        c_oe;
  } tvp_tx_s;

  tvp_tx_s s_reg;
  tvp_tx_s s_next;

  always_comb begin
    s_next = s_reg;
    if (ce) begin
      if (!s_reg.act) begin
        if (go) begin
          s_next.act  = 1'b1;
          s_next.sh   = word;
          s_next.bitn = 4'h0;
          s_next.cyc  = 7'h00;
        end
      // (R23) bit cell period
      end else if (s_reg.cyc == BITM) begin
        s_next.cyc = 7'h00;
        s_next.sh  = {s_reg.sh[13:0], 1'b0};
        // (R19) exactly fifteen pulses
        if (s_reg.bitn == LAST) begin
          s_next.act = 1'b0;
        end else begin
          s_next.bitn = s_reg.bitn + 4'h1;
        end
      end else begin
        s_next.cyc = s_reg.cyc + 7'h01;
      end
      // (R21) a one bit pulls the line low
      s_next.d_oe = s_next.act & s_next.sh[14];
      // (R22) lines released between bursts
      s_next.c_oe = s_next.act && (s_next.cyc >= CLO);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign busy    = s_reg.act;
  assign data_oe = s_reg.d_oe;
  assign clk_oe  = s_reg.c_oe;

  a_burst_start: // R19
    assert property (@(posedge clk) disable iff (!nrst)
      ce && go && !s_reg.act |=> s_reg.act && s_reg.bitn == 4'h0 && s_reg.sh == $past(word))
    else $error("burst did not start on request");

  a_lines_idle: // R22
    assert property (@(posedge clk) disable iff (!nrst)
      !s_reg.act && !$past(s_reg.act) |-> !data_oe && !clk_oe)
    else $error("display line conducting outside a burst");

endmodule
`default_nettype wire

// ---- design/tvp_preset.sv ----
// Tuning preset controller: keys, remote fine tune, store cycle, scan, outputs.
// Assumes an APB master on CLOCK and asynchronous pins for all key and link inputs.
// Function
// (R1) Store tuning, band, fine tune on store-low
// (R2) Ignore store during search or store
// (R3) Erase old word before writing new
// (R4) Store-high steps band cyclically
// (R5) Panel fine tune decoded as three levels
// (R6) One step per panel press
// (R7) Slow remote thresholds 1.8 ms, 1.7 ms
// (R8) Fast remote thresholds 120 us, 80 us
// (R9) Held remote command steps every 0.56 s
// (R10) Short remote train gives one step
// (R11) Program lines read as binary value
// (R12) Memory timing differs erase versus write
// (R13) Outside pulses memory supply by timing
// (R14) Auto fast up halved on UHF, S
// (R15) Medium down is quarter of fast up
// (R16) Slow up 67.7 Hz, down 8.4 Hz
// (R17) Manual rate halved on UHF, S
// (R18) 13-bit pulse tuning output, 12 stored
// (R19) Display burst of 15 clock pulses
// (R20) Burst holds tuning, band, program, search
// (R21) Burst bits sent inverted
// (R22) Display lines off between bursts
// (R23) Display bit period 3.6 us
// (R24) Erase pulses 115 us in 231 us
// (R25) Write pulses 115 us in 462 us
// (R26) Fine tune square wave, eight duties
// (R27) Qualified key edge fires once
// (R28) Fixed burst field order
`timescale 1ns/1ps
`default_nettype none
`include "tvp_defs.svh"
module tvp_preset
  import tvp_pkg::*;
#(
  parameter int unsigned ERASE_PER   = `TVP_CYC_DN(`TVP_ERASE_T_US * 1000),
  parameter int unsigned WRITE_PER   = `TVP_CYC_DN(`TVP_WRITE_T_US * 1000),
  parameter int unsigned ERASE_NUM   = `TVP_ERASE_PULSES,
  parameter int unsigned WRITE_NUM   = `TVP_WRITE_PULSES,
  parameter int unsigned REM_UP_SLOW = `TVP_CYC_DN(`TVP_REM_UP_SLOW_US * 1000),
  parameter int unsigned REM_DN_SLOW = `TVP_CYC_DN(`TVP_REM_DN_SLOW_US * 1000),
  parameter int unsigned REPEAT_CYC  = `TVP_CYC_DN(`TVP_REPEAT_MS * 1000000),
  parameter int unsigned ACCEPT_CYC  = `TVP_CYC_DN(`TVP_ACCEPT_MS * 1000000),
  parameter int unsigned SLOW_UP_PER = `TVP_CLK_HZ * 10 / `TVP_SLOW_UP_DHZ,
  parameter int unsigned SLOW_DN_PER = `TVP_CLK_HZ * 10 / `TVP_SLOW_DN_DHZ,
  parameter int unsigned BURST_PER   = `TVP_CYC_DN(`TVP_BURST_REP_US * 1000)
) (
  // Clock, reset, enable
  input  wire logic        CLOCK,
  input  wire logic        NRST,
  input  wire logic        CE,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Three-level keys as high and low comparator lines
  input  wire logic        STORE_HI,
  input  wire logic        STORE_LO,
  input  wire logic        FT_HI,
  input  wire logic        FT_LO,
  // Remote, program lines, search oscillator
  input  wire logic        REMOTE_IN,
  input  wire logic [3:0]  PROGRAM_SELECT,
  input  wire logic        SPEED_OSC,
  // Preset memory
  output logic [3:0]       MEM_ADDR,
  output logic [16:0]      MEM_WORD,
  output logic             MEM_ERASE,
  output logic             MEM_WRITE,
  output logic             MEM_TIMING_O,
  output logic             MEM_TIMING_OE,
  // Tuning and fine tune outputs
  output logic             TUNE_O,
  output logic             TUNE_OE,
  output logic             FT_O,
  output logic             FT_OE,
  // Display link
  output logic             DCLK_O,
  output logic             DCLK_OE,
  output logic             DDATA_O,
  output logic             DDATA_OE
);
  localparam logic [23:0] EP  = 24'(ERASE_PER - 1);
  localparam logic [23:0] WP  = 24'(WRITE_PER - 1);
  localparam logic [9:0]  EN  = 10'(ERASE_NUM - 1);
  localparam logic [9:0]  WN  = 10'(WRITE_NUM - 1);
  localparam logic [23:0] MW  = 24'(ERASE_PER * `TVP_MEM_W_US / `TVP_ERASE_T_US);
  localparam logic [23:0] RUS = 24'(REM_UP_SLOW);
  localparam logic [23:0] RDS = 24'(REM_DN_SLOW);
  localparam logic [23:0] RUF = 24'(`TVP_CYC_DN(`TVP_REM_UP_FAST_US * 1000));
  localparam logic [23:0] RDF = 24'(`TVP_CYC_DN(`TVP_REM_DN_FAST_US * 1000));
  localparam logic [23:0] REP = 24'(REPEAT_CYC - 1);
  localparam logic [23:0] ACC = 24'(ACCEPT_CYC);
  localparam logic [23:0] SUP = 24'(SLOW_UP_PER - 1);
  localparam logic [23:0] SDN = 24'(SLOW_DN_PER - 1);
  localparam logic [23:0] BP  = 24'(BURST_PER - 1);
  localparam logic [10:0] FP  = 11'(`TVP_CLK_HZ / `TVP_FT_HZ - 1);
  localparam logic [13:0] FPW = 14'(`TVP_CLK_HZ / `TVP_FT_HZ);

  typedef struct packed {
    logic [3:0]       key1;
    logic [3:0]       key2;
    logic [3:0]       prg1;
    logic [3:0]       prg2;
    logic             rem1;
    logic             rem2;
    logic             remd;
    logic             osc1;
    logic             osc2;
    logic             oscd;
    logic [1:0][1:0]  cand;
    logic [1:0][1:0]  lvl;
    logic [1:0][23:0] kcnt;
    logic [23:0]      remw;
    logic [23:0]      rrep;
    logic             ract;
    logic             rseen;
    logic             rdn;
    logic [12:0]      tune;
    logic [1:0]       band;
    logic [2:0]       ft;
    tvp_st_e          st;
    logic [23:0]      pcnt;
    logic [9:0]       npul;
    logic [16:0]      word;
    logic [3:0]       addr;
    logic             mem_on;
    logic [6:0]       ctrl;
    logic [31:0]      prdata;
    logic [2:0]       odiv;
    logic [23:0]      scnt;
    logic [12:0]      acc;
    logic             tun_o;
    logic [10:0]      fcnt;
    logic             ft_o;
    logic [23:0]      bcnt;
    logic             go;
  } tvp_state_s;

  tvp_state_s s_reg;
  tvp_state_s s_next;
  logic [1:0]  ev_hi;
  logic [1:0]  ev_lo;
  logic        rup;
  logic        rdn;
  logic        rstep;
  logic        wr_tune;
  logic [31:0] rdata;
  logic        unmapped;

  always_comb begin
    rdata    = 32'h0;
    unmapped = 1'b0;
    case (PADDR)
      `TVP_OFS_CTRL: rdata = {25'h0, s_reg.ctrl};
      `TVP_OFS_TUNE: rdata = {9'h0, s_reg.ft, 2'h0, s_reg.band, 3'h0, s_reg.tune};
      `TVP_OFS_STAT: rdata = {22'h0, s_reg.ract, s_reg.mem_on, s_reg.prg2, 2'h0, s_reg.st};
      default:       unmapped = 1'b1;
    endcase
  end

  always_comb begin
    logic [1:0]  code;
    logic        fall;
    logic        fast;
    logic        srch;
    tvp_scan_e   mode;
    logic [2:0]  rlim;
    logic        ftick;
    logic        stick;
    logic        tup;
    logic        tdn;
    logic        fup;
    logic        fdn;
    logic [2:0]  sel;
    logic [13:0] thr;
    code    = 2'h0;
    fall    = 1'b0;
    fast    = s_reg.ctrl[`TVP_CTRL_FASTREM];
    srch    = s_reg.ctrl[`TVP_CTRL_SEARCH];
    mode    = tvp_scan_e'(s_reg.ctrl[`TVP_CTRL_MODE_LSB +: 3]);
    rlim    = 3'h0;
    ftick   = 1'b0;
    stick   = 1'b0;
    tup     = 1'b0;
    tdn     = 1'b0;
    fup     = 1'b0;
    fdn     = 1'b0;
    sel     = 3'h0;
    thr     = 14'h0;
    ev_hi   = 2'h0;
    ev_lo   = 2'h0;
    rup     = 1'b0;
    rdn     = 1'b0;
    rstep   = 1'b0;
    wr_tune = 1'b0;
    s_next  = s_reg;
    if (CE) begin
      s_next.key1 = {FT_LO, FT_HI, STORE_LO, STORE_HI};
      s_next.key2 = s_reg.key1;
      s_next.prg1 = PROGRAM_SELECT;
      s_next.prg2 = s_reg.prg1;
      s_next.rem1 = REMOTE_IN;
      s_next.rem2 = s_reg.rem1;
      s_next.osc1 = SPEED_OSC;
      s_next.osc2 = s_reg.osc1;
      for (int k = 0; k < 2; k++) begin
        // (R5) middle, high, low decode
        if (s_reg.key2[2*k] == s_reg.key2[2*k+1]) begin
          code = 2'h0;
        end else begin
          code = {s_reg.key2[2*k+1], s_reg.key2[2*k]};
        end
        // (R27) level must stand the acceptance time
        if (code != s_reg.cand[k]) begin
          s_next.cand[k] = code;
          s_next.kcnt[k] = 24'h0;
        end else if (s_reg.kcnt[k] != ACC) begin
          s_next.kcnt[k] = s_reg.kcnt[k] + 24'h1;
        end else if (s_reg.lvl[k] != code) begin
          s_next.lvl[k] = code;
          // (R6) only a press from middle counts
          ev_hi[k] = (s_reg.lvl[k] == 2'h0) && (code == 2'h1);
          ev_lo[k] = (s_reg.lvl[k] == 2'h0) && (code == 2'h2);
        end
      end

      // Remote pulse width measurement
      s_next.remd = s_reg.rem2;
      fall = s_reg.remd & ~s_reg.rem2;
      if (fall) begin
        s_next.remw = 24'h0;
      end else if (s_reg.rem2 && !(&s_reg.remw)) begin
        s_next.remw = s_reg.remw + 24'h1;
      end
      // (R7) (R8) width thresholds per variant
      rup = fall && (s_reg.remw > (fast ? RUF : RUS));
      rdn = fall && (s_reg.remw != 24'h0) && (s_reg.remw < (fast ? RDF : RDS));
      if (s_reg.ract) begin
        // (R9) repeat while pulses keep coming
        if (s_reg.rrep == REP) begin
          s_next.rrep  = 24'h0;
          s_next.rseen = 1'b0;
          rstep        = s_reg.rseen;
          s_next.ract  = s_reg.rseen;
        end else begin
          s_next.rrep = s_reg.rrep + 24'h1;
        end
        if ((rup && !s_reg.rdn) || (rdn && s_reg.rdn)) begin
          s_next.rseen = 1'b1;
        end
      end else if (rup || rdn) begin
        // (R10) first pulse gives one step at once
        rstep        = 1'b1;
        s_next.ract  = 1'b1;
        s_next.rdn   = rdn;
        s_next.rrep  = 24'h0;
        s_next.rseen = 1'b0;
      end
      fup = ev_hi[1] | (rstep & ~s_next.rdn);
      fdn = ev_lo[1] | (rstep & s_next.rdn);
      if (fup && !fdn && s_reg.ft != 3'h7) begin
        s_next.ft = s_reg.ft + 3'h1;
      end else if (fdn && !fup && s_reg.ft != 3'h0) begin
        s_next.ft = s_reg.ft - 3'h1;
      end

      // (R4) band steps cyclically
      if (ev_hi[0]) begin
        s_next.band = s_reg.band + 2'h1;
      end

      case (s_reg.st)
        ST_IDLE: begin
          // (R1) (R2) (R11) latch word for selected program
          if (ev_lo[0] && !srch) begin
            s_next.st   = ST_ERASE;
            s_next.word = {s_reg.tune[12:1], s_reg.band, s_reg.ft};
            s_next.addr = s_reg.prg2;
            s_next.pcnt = 24'h0;
            s_next.npul = 10'h0;
          end
        end
        ST_ERASE, ST_WRITE: begin
          // (R24) (R25) period per phase
          if (s_reg.pcnt == ((s_reg.st == ST_ERASE) ? EP : WP)) begin
            s_next.pcnt = 24'h0;
            if (s_reg.npul == ((s_reg.st == ST_ERASE) ? EN : WN)) begin
              s_next.npul = 10'h0;
              // (R3) erase always precedes write
              s_next.st   = (s_reg.st == ST_ERASE) ? ST_WRITE : ST_IDLE;
            end else begin
              s_next.npul = s_reg.npul + 10'h1;
            end
          end else begin
            s_next.pcnt = s_reg.pcnt + 24'h1;
          end
        end
        default: s_next.st = ST_IDLE;
      endcase
      // (R12) (R13) gate for the supply pulses
      s_next.mem_on = (s_reg.st != ST_IDLE) && (s_reg.pcnt < MW);

      // (R14) (R15) (R17) oscillator divide by band
      case (mode)
        SC_FAST_UP, SC_MAN_UP, SC_MAN_DN: rlim = s_reg.band[1] ? 3'h1 : 3'h0;
        SC_MED_DN:                        rlim = s_reg.band[1] ? 3'h7 : 3'h3;
        default:                          rlim = 3'h0;
      endcase
      s_next.oscd = s_reg.osc2;
      if (s_reg.osc2 && !s_reg.oscd) begin
        ftick       = (s_reg.odiv >= rlim);
        s_next.odiv = ftick ? 3'h0 : s_reg.odiv + 3'h1;
      end
      // (R16) fixed slow rates
      stick       = (s_reg.scnt >= ((mode == SC_SLOW_UP) ? SUP : SDN));
      s_next.scnt = stick ? 24'h0 : s_reg.scnt + 24'h1;
      tup = srch && (((mode == SC_FAST_UP || mode == SC_MAN_UP) && ftick) ||
                     (mode == SC_SLOW_UP && stick));
      tdn = srch && (((mode == SC_MED_DN || mode == SC_MAN_DN) && ftick) ||
                     (mode == SC_SLOW_DN && stick));
      if (tup && s_reg.tune != 13'h1fff) begin
        s_next.tune = s_reg.tune + 13'h1;
      end else if (tdn && s_reg.tune != 13'h0) begin
        s_next.tune = s_reg.tune - 13'h1;
      end

      // (R18) carry of a 13-bit accumulator
      {s_next.tun_o, s_next.acc} = {1'b0, s_reg.acc} + {1'b0, s_reg.tune};

      // (R26) eight duty positions, mid during search
      sel          = srch ? `TVP_FT_MID : s_reg.ft;
      thr          = (14'(sel) + 14'h1) * FPW;
      s_next.fcnt  = (s_reg.fcnt == FP) ? 11'h0 : s_reg.fcnt + 11'h1;
      s_next.ft_o  = (s_reg.fcnt < thr[13:3]);

      s_next.go   = (s_reg.bcnt == BP);
      s_next.bcnt = s_next.go ? 24'h0 : s_reg.bcnt + 24'h1;

      // APB read data follows the address while selected
      if (PSEL) begin
        s_next.prdata = rdata;
      end
      if (PSEL && PENABLE && PWRITE && PADDR == `TVP_OFS_CTRL) begin
        s_next.ctrl = PWDATA[6:0];
      end
      wr_tune = PSEL && PENABLE && PWRITE && (PADDR == `TVP_OFS_TUNE);
      if (wr_tune) begin
        s_next.tune = PWDATA[12:0];
        s_next.band = PWDATA[`TVP_TUNE_BAND_LSB +: 2];
        s_next.ft   = PWDATA[`TVP_TUNE_FT_LSB +: 3];
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // (R20) (R28) tuning msb first, band, program, search
  tvp_disp_tx u_disp (
    .clk     (CLOCK),
    .nrst    (NRST),
    .ce      (CE),
    .go      (s_reg.go),
    .word    ({s_reg.tune[12:5], s_reg.band, s_reg.prg2, s_reg.ctrl[`TVP_CTRL_SEARCH]}),
    .busy    (),
    .data_oe (DDATA_OE),
    .clk_oe  (DCLK_OE)
  );

  assign PRDATA        = s_reg.prdata;
  assign PREADY        = CE;
  assign PSLVERR       = PSEL && PENABLE && unmapped;
  assign MEM_ADDR      = s_reg.addr;
  assign MEM_WORD      = s_reg.word;
  assign MEM_ERASE     = (s_reg.st == ST_ERASE);
  assign MEM_WRITE     = (s_reg.st == ST_WRITE);
  assign MEM_TIMING_O  = 1'b0;
  assign MEM_TIMING_OE = s_reg.mem_on;
  assign TUNE_O        = 1'b0;
  assign TUNE_OE       = ~s_reg.tun_o;
  assign FT_O          = 1'b0;
  assign FT_OE         = ~s_reg.ft_o;
  assign DCLK_O        = 1'b0;
  assign DDATA_O       = 1'b0;

  a_store_start: // R1
    assert property (@(posedge CLOCK) disable iff (!NRST)
      CE && s_reg.st == ST_IDLE && ev_lo[0] && !s_reg.ctrl[0]
      |=> s_reg.st == ST_ERASE && s_reg.word == $past({s_reg.tune[12:1], s_reg.band, s_reg.ft}))
    else $error("store did not latch the word");

  a_store_block: // R2
    assert property (@(posedge CLOCK) disable iff (!NRST)
      CE && s_reg.ctrl[0] && s_reg.st == ST_IDLE |=> s_reg.st == ST_IDLE)
    else $error("store started during search");

  a_erase_first: // R3
    assert property (@(posedge CLOCK) disable iff (!NRST)
      s_reg.st == ST_IDLE ##1 s_reg.st != ST_IDLE |-> s_reg.st == ST_ERASE)
    else $error("store cycle did not begin with erase");

  a_band_step: // R4
    assert property (@(posedge CLOCK) disable iff (!NRST)
      CE && ev_hi[0] && !wr_tune |=> s_reg.band == $past(s_reg.band) + 2'h1)
    else $error("band did not advance by one");

  a_panel_step: // R6
    assert property (@(posedge CLOCK) disable iff (!NRST)
      CE && ev_hi[1] && !rstep && !wr_tune && s_reg.ft != 3'h7
      |=> s_reg.ft == $past(s_reg.ft) + 3'h1)
    else $error("panel press did not give one step");

  a_remote_up: // R7
    assert property (@(posedge CLOCK) disable iff (!NRST)
      CE && !s_reg.ract && !s_reg.ctrl[1] && s_reg.remd && !s_reg.rem2 && s_reg.remw > RUS
      |=> s_reg.ract && !s_reg.rdn)
    else $error("wide remote pulse not taken as up");

  a_mem_gate: // R12
    assert property (@(posedge CLOCK) disable iff (!NRST)
      s_reg.mem_on |-> $past(s_reg.st) != ST_IDLE)
    else $error("memory timing active outside store");

  a_scan_halt: // R14
    assert property (@(posedge CLOCK) disable iff (!NRST)
      CE && !s_reg.ctrl[0] && !wr_tune |=> s_reg.tune == $past(s_reg.tune))
    else $error("tuning moved with search off");

endmodule
`default_nettype wire

// ---- tb/tvp_osd_mem.sv ----
// Far-side model: on-screen bar display receiver and preset memory.
// Assumes pulled-up open-drain lines and enables that are high while conducting.
`timescale 1ns/1ps
`default_nettype none
module tvp_osd_mem (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Display link enables
  input  wire logic        dclk_oe,
  input  wire logic        ddata_oe,
  // Memory side
  input  wire logic        tim_oe,
  input  wire logic        erase,
  input  wire logic        write,
  input  wire logic [3:0]  addr,
  input  wire logic [16:0] word,
  // Observations
  output logic [14:0]      bits,
  output logic [4:0]       nbits,
  output logic [7:0]       bursts,
  output logic [7:0]       ecnt,
  output logic [7:0]       wcnt,
  output logic [16:0]      mem_at
);
  logic [16:0] mem [16];
  logic [14:0] sh;
  logic [4:0]  cnt;
  logic [7:0]  gap;
  logic        dclk_q;
  logic        tim_q;
  assign mem_at = mem[addr];
  always @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < 16; i++) mem[i] <= 17'h0;
      {sh, cnt, gap, dclk_q, tim_q, bits, nbits, bursts, ecnt, wcnt} <= '0;
    end else begin
      dclk_q <= dclk_oe;
      tim_q <= tim_oe;
      // Conducting line reads low; sample data as the clock line falls
      if (dclk_oe && !dclk_q) begin
        sh <= {sh[13:0], !ddata_oe};
        cnt <= cnt + 5'h1;
        gap <= 8'h0;
      end else if (gap != 8'hff) begin
        gap <= gap + 8'h1;
      end
      if (gap == 8'd200 && cnt != 5'h0) begin
        bits <= sh;
        nbits <= cnt;
        bursts <= bursts + 8'h1;
        cnt <= 5'h0;
      end
      if (tim_oe && !tim_q && erase) begin
        mem[addr] <= 17'h1ffff;
        ecnt <= ecnt + 8'h1;
      end
      if (tim_oe && !tim_q && write) begin
        mem[addr] <= mem[addr] & word;
        wcnt <= wcnt + 8'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/tvp_preset_bench.sv ----
// Self-checking bench of the tuning preset controller.
// Assumes shortened counts and the far-side model beside it.
`timescale 1ns/1ps
`default_nettype none
module tvp_preset_bench;
  logic        clk, nrst, psel, pen, pwr, pready, perr, rem, osc, err;
  logic        dck, ddt, tim, ers, wrt, ce, tun, ftoe;
  logic [7:0]  pa, nbur, ec, wc, n0;
  logic [31:0] pwd, prd, rd;
  logic [3:0]  kv, prog, maddr;
  logic [16:0] mword, mem_at;
  logic [14:0] bits;
  logic [4:0]  nb;
  logic [12:0] t;
  logic [1:0]  b;
  logic [2:0]  f;
  int          num_errors, tests_run, cyc, j, ct, cf, wd[4];
  tvp_preset #(.ACCEPT_CYC(4), .REPEAT_CYC(50), .ERASE_PER(20), .WRITE_PER(40), .ERASE_NUM(3), .WRITE_NUM(3),
    .REM_UP_SLOW(30), .REM_DN_SLOW(20), .SLOW_UP_PER(16), .SLOW_DN_PER(32), .BURST_PER(1600)) u_dut (
    .CLOCK(clk), .NRST(nrst), .CE(ce), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
    .PWDATA(pwd), .PRDATA(prd), .PREADY(pready), .PSLVERR(perr), .STORE_HI(kv[0]), .STORE_LO(kv[1]),
    .FT_HI(kv[2]), .FT_LO(kv[3]), .REMOTE_IN(rem), .PROGRAM_SELECT(prog), .SPEED_OSC(osc),
    .MEM_ADDR(maddr), .MEM_WORD(mword), .MEM_ERASE(ers), .MEM_WRITE(wrt), .MEM_TIMING_O(),
    .MEM_TIMING_OE(tim), .TUNE_O(), .TUNE_OE(tun), .FT_O(), .FT_OE(ftoe), .DCLK_O(), .DCLK_OE(dck),
    .DDATA_O(), .DDATA_OE(ddt));
  tvp_osd_mem u_far (.clk(clk), .nrst(nrst), .dclk_oe(dck), .ddata_oe(ddt), .tim_oe(tim), .erase(ers),
    .write(wrt), .addr(maddr), .word(mword), .bits(bits), .nbits(nb), .bursts(nbur), .ecnt(ec),
    .wcnt(wc), .mem_at(mem_at));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) if (cyc % 4 == 3) osc <= ~osc;
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, rd, e);
  endtask
  task automatic press(input logic [3:0] v);
    kv <= v;
    repeat (20) @(posedge clk);
    kv <= 4'h0;
    repeat (20) @(posedge clk);
  endtask
  function automatic logic [31:0] tv();
    return {9'h0, f, 2'h0, b, 3'h0, t};
  endfunction
  initial begin
    {nrst, psel, pen, pwr, pa, pwd, kv, rem, prog, osc} = '0;
    ce = 1'b1;
    num_errors = 0;
    tests_run = 0;
    cyc = 0;
    wd = '{40, 10, 3100, 1000};
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rchk(8'h00, 32'h0, "ctrl");
    rchk(8'h0c, 32'h0, "unmapped");
    chk("slverr", 32'(err), 32'h1);
    $display("test reset done");
    t = 13'h1abc;
    b = 2'h1;
    f = 3'h5;
    apb(1'b1, 8'h04, tv());
    prog <= 4'h9;
    rchk(8'h04, tv(), "tune");
    repeat (4) @(posedge clk);
    rchk(8'h08, 32'h90, "program");
    for (j = 0; j < 3; j++) begin
      press(4'h1);
      b = b + 2'h1;
      rchk(8'h04, tv(), "band");
    end
    press(4'h4);
    f = f + 3'h1;
    rchk(8'h04, tv(), "panel up");
    press(4'h8);
    f = f - 3'h1;
    rchk(8'h04, tv(), "panel down");
    ce <= 1'b0;
    press(4'h4);
    ce <= 1'b1;
    rchk(8'h04, tv(), "frozen key");
    ct = 0;
    cf = 0;
    for (j = 0; j < 8192; j++) begin
      @(posedge clk);
      ct += !tun;
      cf += (j < 1444) && !ftoe;
    end
    chk("tune density", ct, 32'(t));
    chk("fine duty", cf, (f + 1) * 1444 / 8);
    $display("test keys done");
    for (j = 0; j < 4; j++) begin
      apb(1'b1, 8'h00, (j >= 2) ? 32'h2 : 32'h0);
      rem <= 1'b1;
      repeat (wd[j]) @(posedge clk);
      rem <= 1'b0;
      repeat (120) @(posedge clk);
      f = (j % 2 == 0) ? f + 3'h1 : f - 3'h1;
      rchk(8'h04, tv(), "remote");
    end
    apb(1'b1, 8'h00, 32'h0);
    repeat (4) begin
      rem <= 1'b1;
      repeat (15) @(posedge clk);
      rem <= 1'b0;
      repeat (25) @(posedge clk);
    end
    repeat (120) @(posedge clk);
    f = f - 3'h4;
    rchk(8'h04, tv(), "remote repeat");
    $display("test remote done");
    press(4'h2);
    repeat (400) @(posedge clk);
    chk("erase pulses", 32'(ec), 32'h3);
    chk("write pulses", 32'(wc), 32'h3);
    chk("stored word", 32'(mem_at), 32'({t[12:1], b, f}));
    chk("store program", 32'(maddr), 32'h9);
    apb(1'b1, 8'h00, 32'h1);
    press(4'h2);
    repeat (400) @(posedge clk);
    chk("blocked store", 32'(ec), 32'h3);
    $display("test store done");
    j = 0;
    n0 = nbur;
    while (nbur != n0 + 8'h2 && j < 6000) begin
      @(posedge clk);
      j++;
    end
    chk("burst pulses", 32'(nb), 32'd15);
    chk("burst word", 32'(bits), {17'h0, ~{t[12:5], b, prog, 1'b1}});
    chk("idle lines", 32'({dck, ddt}), 32'h0);
    $display("test display done");
    for (j = 0; j < 2; j++) begin
      apb(1'b1, 8'h04, 32'(j) << 17);
      apb(1'b1, 8'h00, 32'h11);
      repeat (800) @(posedge clk);
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b0, 8'h04, 32'h0);
      wd[j] = rd[12:0];
    end
    chk("vhf fast up", 32'(wd[0] inside {[99:102]}), 32'h1);
    chk("uhf fast up", 32'(wd[0] - 2 * wd[1] inside {[-2:2]}), 32'h1);
    $display("test scan done");
    wrap_up();
  end
endmodule
`default_nettype wire
